//--- shared/crma_defines.vh
// Constants for the configuration message access engine
`ifndef CRMA_DEFINES_VH
`define CRMA_DEFINES_VH

// ==========================================================
// Control tokens
`define CRMA_TOK_WRITE 8'hC0
`define CRMA_TOK_READ 8'hC1
`define CRMA_TOK_PREAD 8'h25
`define CRMA_TOK_ACK 8'h03
`define CRMA_TOK_NACK 8'h04
`define CRMA_TOK_END 8'h01

// ==========================================================
// Reply identifier
`define CRMA_DEST_BYTES 8'h03
`define CRMA_NOREPLY_LOW 8'hFF

// ==========================================================
// Register spaces
`define CRMA_CFG_COUNT 16'h0008
`define CRMA_CFG_RESET 32'h00000000
`define CRMA_PERIPH_BYTES 9'h020
`define CRMA_WORD_BYTES 8'h04
`define CRMA_PS_RES_LOW 8'h0C
`define CRMA_PS_SHIFT 8
`define CRMA_PS_COUNT 24'h000004
`define CRMA_PS_RESET 32'h00000000

`endif

//--- src/crma_engine.v
// Configuration message interpreter and processor status access port
`include "crma_defines.vh"

// Overview of operation
// - Write whose reply identifier has low byte all ones gets no reply.
// - Multi-byte fields travel most significant byte first, both directions.
// - Status access moves one word; resource is number shifted 8, ORed 0x0C.
// - Write message: token 192, reply id, 16-bit number, 32-bit data, token 1.
// - Write answered 3 then 1 on success, 4 then 1 on failure.
// - Read message: token 193, reply id, 16-bit number, token 1.
// - Read answered 3, 32-bit value, 1; failure answered 4 then 1.
// - Peripheral read: token 37, reply id, 8-bit number, 8-bit size, 1.
// - Peripheral read answered 3, data bytes, 1; failure 4 then 1.
module crma_engine
(
   input wire i_mclk,
   input wire i_reset,
   input wire i_rx_valid,
   input wire i_rx_ctrl,
   input wire [7:0] i_rx_data,
   output wire o_rx_ready,
   output wire o_tx_valid,
   output wire o_tx_ctrl,
   output wire [7:0] o_tx_data,
   output wire [23:0] o_tx_dest,
   input wire i_tx_ready,
   input wire i_ps_valid,
   input wire i_ps_write,
   input wire [31:0] i_ps_resource,
   input wire [31:0] i_ps_wdata,
   output wire [31:0] o_ps_rdata,
   output wire o_ps_done,
   output wire o_ps_error
);
   localparam [9:0] ST_OP = 10'h001;
   localparam [9:0] ST_DEST = 10'h002;
   localparam [9:0] ST_REG = 10'h004;
   localparam [9:0] ST_DATA = 10'h008;
   localparam [9:0] ST_SIZE = 10'h010;
   localparam [9:0] ST_END = 10'h020;
   localparam [9:0] ST_DRAIN = 10'h040;
   localparam [9:0] ST_HEAD = 10'h080;
   localparam [9:0] ST_BODY = 10'h100;
   localparam [9:0] ST_TAIL = 10'h200;
   reg [9:0] state_reg, state_next;
   reg [7:0] cnt_reg, cnt_next, size_reg, size_next, tx_data_reg, tx_data_next;
   reg [23:0] dest_reg, dest_next;
   reg [15:0] regno_reg, regno_next;
   reg [31:0] data_reg, data_next;
   reg is_w_reg, is_w_next, is_p_reg, is_p_next, ok_reg, ok_next, fail_reg, fail_next, tx_ctrl_reg, tx_ctrl_next;
   reg wr_en;
   reg [31:0] ps_mem [0:3];
   reg [31:0] ps_rdata_reg;
   reg ps_done_reg, ps_error_reg;
   wire [7:0] rd_byte;

   // ==========================================================
   // Status resource decode and message decode helpers
   function crma_ps_ok(input [31:0] res);
      crma_ps_ok = (res[7:0] == `CRMA_PS_RES_LOW) && (res[31:`CRMA_PS_SHIFT] < `CRMA_PS_COUNT);
   endfunction
   wire rx_take = i_rx_valid && o_rx_ready;
   wire tok_end = i_rx_ctrl && (i_rx_data == `CRMA_TOK_END);
   wire suppress = is_w_reg && (dest_reg[7:0] == `CRMA_NOREPLY_LOW);
   wire [9:0] reply_state = suppress ? ST_OP : ST_HEAD;
   wire [8:0] p_span = {1'b0, regno_reg[7:0]} + {1'b0, size_reg};
   wire acc_ok = is_p_reg ? ((size_reg != 8'h00) && (p_span <= `CRMA_PERIPH_BYTES))
                          : (regno_reg < `CRMA_CFG_COUNT);
   wire [7:0] last_cnt = is_p_reg ? (size_reg - 8'h01) : (`CRMA_WORD_BYTES - 8'h01);
   wire [7:0] rd_cnt = (state_reg == ST_HEAD) ? 8'h00 : (cnt_reg + 8'h01);
   wire [4:0] rd_addr = is_p_reg ? (regno_reg[4:0] + rd_cnt[4:0]) : {regno_reg[2:0], rd_cnt[1:0]};
   assign o_rx_ready = |(state_reg & (ST_OP | ST_DEST | ST_REG | ST_DATA | ST_SIZE | ST_END | ST_DRAIN));
   assign o_tx_valid = |(state_reg & (ST_HEAD | ST_BODY | ST_TAIL));
   assign o_tx_ctrl = tx_ctrl_reg;
   assign o_tx_data = tx_data_reg;
   assign o_tx_dest = dest_reg;

   crma_regbank u_bank
   (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_wr_en(wr_en),
      .i_wr_index(regno_reg[2:0]),
      .i_wr_data(data_reg),
      .i_rd_addr(rd_addr),
      .o_rd_byte(rd_byte)
   );
   // ==========================================================
   // Next state
   always @*
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      dest_next = dest_reg;
      regno_next = regno_reg;
      data_next = data_reg;
      size_next = size_reg;
      is_w_next = is_w_reg;
      is_p_next = is_p_reg;
      ok_next = ok_reg;
      fail_next = fail_reg;
      tx_data_next = tx_data_reg;
      tx_ctrl_next = tx_ctrl_reg;
      wr_en = 1'b0;
      case (state_reg)
         ST_OP:
            if (rx_take)
            begin
               cnt_next = 8'h00;
               fail_next = 1'b0;
               ok_next = 1'b0;
               if (i_rx_ctrl && ((i_rx_data == `CRMA_TOK_WRITE) || (i_rx_data == `CRMA_TOK_READ) ||
                                 (i_rx_data == `CRMA_TOK_PREAD)))
               begin
                  is_w_next = (i_rx_data == `CRMA_TOK_WRITE);
                  is_p_next = (i_rx_data == `CRMA_TOK_PREAD);
                  state_next = ST_DEST;
               end
               else if (!tok_end)
                  state_next = ST_DRAIN;
            end
         ST_DEST:
            if (rx_take)
            begin
               dest_next = {dest_reg[15:0], i_rx_data};
               cnt_next = cnt_reg + 8'h01;
               if (i_rx_ctrl)
                  state_next = tok_end ? ST_OP : ST_DRAIN;
               else if (cnt_reg == (`CRMA_DEST_BYTES - 8'h01))
               begin
                  cnt_next = 8'h00;
                  state_next = ST_REG;
               end
            end
         ST_REG, ST_DATA, ST_SIZE:
            if (rx_take)
            begin
               if (i_rx_ctrl)
               begin
                  fail_next = 1'b1;
                  tx_ctrl_next = 1'b1;
                  tx_data_next = `CRMA_TOK_NACK;
                  state_next = tok_end ? reply_state : ST_DRAIN;
               end
               else
               begin
                  cnt_next = cnt_reg + 8'h01;
                  if (state_reg == ST_REG)
                  begin
                     regno_next = {regno_reg[7:0], i_rx_data};
                     if (is_p_reg || (cnt_reg == 8'h01))
                     begin
                        cnt_next = 8'h00;
                        state_next = is_w_reg ? ST_DATA : (is_p_reg ? ST_SIZE : ST_END);
                     end
                  end
                  else if (state_reg == ST_DATA)
                  begin
                     data_next = {data_reg[23:0], i_rx_data};
                     if (cnt_reg == (`CRMA_WORD_BYTES - 8'h01))
                        state_next = ST_END;
                  end
                  else
                  begin
                     size_next = i_rx_data;
                     state_next = ST_END;
                  end
               end
            end
         ST_END:
            if (rx_take)
            begin
               tx_ctrl_next = 1'b1;
               tx_data_next = `CRMA_TOK_NACK;
               fail_next = !tok_end;
               state_next = ST_DRAIN;
               if (tok_end)
               begin
                  ok_next = acc_ok;
                  wr_en = is_w_reg && acc_ok;
                  tx_data_next = acc_ok ? `CRMA_TOK_ACK : `CRMA_TOK_NACK;
                  state_next = reply_state;
               end
            end
         ST_DRAIN:
            if (rx_take && tok_end)
               state_next = fail_reg ? reply_state : ST_OP;
         ST_HEAD:
            if (i_tx_ready)
            begin
               cnt_next = 8'h00;
               tx_ctrl_next = 1'b1;
               tx_data_next = `CRMA_TOK_END;
               state_next = ST_TAIL;
               if (ok_reg && !is_w_reg)
               begin
                  tx_ctrl_next = 1'b0;
                  tx_data_next = rd_byte;
                  state_next = ST_BODY;
               end
            end
         ST_BODY:
            if (i_tx_ready)
            begin
               cnt_next = rd_cnt;
               tx_data_next = rd_byte;
               if (cnt_reg == last_cnt)
               begin
                  tx_ctrl_next = 1'b1;
                  tx_data_next = `CRMA_TOK_END;
                  state_next = ST_TAIL;
               end
            end
         ST_TAIL:
            if (i_tx_ready)
               state_next = ST_OP;
         default:
            state_next = ST_OP;
      endcase
   end
   // ==========================================================
   // Message state registers
   always @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         state_reg <= ST_OP;
         cnt_reg <= 8'h00;
         dest_reg <= 24'h000000;
         regno_reg <= 16'h0000;
         data_reg <= 32'h00000000;
         size_reg <= 8'h00;
         is_w_reg <= 1'b0;
         is_p_reg <= 1'b0;
         ok_reg <= 1'b0;
         fail_reg <= 1'b0;
         tx_data_reg <= 8'h00;
         tx_ctrl_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         dest_reg <= dest_next;
         regno_reg <= regno_next;
         data_reg <= data_next;
         size_reg <= size_next;
         is_w_reg <= is_w_next;
         is_p_reg <= is_p_next;
         ok_reg <= ok_next;
         fail_reg <= fail_next;
         tx_data_reg <= tx_data_next;
         tx_ctrl_reg <= tx_ctrl_next;
      end
   end
   // ==========================================================
   // Processor status registers, one word per access
   wire ps_hit = crma_ps_ok(i_ps_resource);
   wire [1:0] ps_index = i_ps_resource[`CRMA_PS_SHIFT+1:`CRMA_PS_SHIFT];
   assign o_ps_rdata = ps_rdata_reg;
   assign o_ps_done = ps_done_reg;
   assign o_ps_error = ps_error_reg;
   genvar gp;
   generate
      for (gp = 0; gp < 4; gp = gp + 1)
      begin : g_ps
         always @(posedge i_mclk)
         begin
            if (i_reset)
               ps_mem[gp] <= `CRMA_PS_RESET;
            else if (i_ps_valid && i_ps_write && ps_hit && (ps_index == gp))
               ps_mem[gp] <= i_ps_wdata;
         end
      end
   endgenerate
   always @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         ps_rdata_reg <= 32'h00000000;
         ps_done_reg <= 1'b0;
         ps_error_reg <= 1'b0;
      end
      else
      begin
         ps_done_reg <= i_ps_valid;
         if (i_ps_valid)
         begin
            ps_error_reg <= !ps_hit;
            ps_rdata_reg <= (ps_hit && !i_ps_write) ? ps_mem[ps_index] : 32'h00000000;
         end
      end
   end

endmodule // crma_engine

//--- src/crma_regbank.v
// Configuration word storage with a big-endian byte read port
`include "crma_defines.vh"

module crma_regbank
(
   input wire i_mclk,
   input wire i_reset,
   input wire i_wr_en,
   input wire [2:0] i_wr_index,
   input wire [31:0] i_wr_data,
   input wire [4:0] i_rd_addr,
   output reg [7:0] o_rd_byte
);

   reg [31:0] mem [0:7];
   wire [31:0] rd_word;

   // ==========================================================
   // Word storage
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1)
      begin : g_word
         always @(posedge i_mclk)
         begin
            if (i_reset)
               mem[gi] <= `CRMA_CFG_RESET;
            else if (i_wr_en && (i_wr_index == gi))
               mem[gi] <= i_wr_data;
         end
      end
   endgenerate

   // ==========================================================
   // Byte view, most significant byte at the lowest address
   assign rd_word = mem[i_rd_addr[4:2]];

   always @*
   begin
      case (i_rd_addr[1:0])
         2'h0: o_rd_byte = rd_word[31:24];
         2'h1: o_rd_byte = rd_word[23:16];
         2'h2: o_rd_byte = rd_word[15:8];
         default: o_rd_byte = rd_word[7:0];
      endcase
   end

endmodule // crma_regbank

//--- verif/crma_engine_assertions.sv
// Port checker for the configuration message engine
`include "crma_defines.vh"
module crma_chk
(
   input wire i_mclk,
   input wire i_reset,
   input wire o_rx_ready,
   input wire o_tx_valid,
   input wire o_tx_ctrl,
   input wire [7:0] o_tx_data,
   input wire i_tx_ready,
   input wire i_ps_valid,
   input wire [31:0] i_ps_resource,
   input wire [31:0] o_ps_rdata,
   input wire o_ps_done,
   input wire o_ps_error
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_reset);
   // ==========================================
   // Reply link
   rx_hold_a: assert property (o_tx_valid |-> !o_rx_ready) else $error("rx ready in reply");
   reply_head_a: assert property ($rose(o_tx_valid) |-> o_tx_ctrl &&
      (o_tx_data == `CRMA_TOK_ACK || o_tx_data == `CRMA_TOK_NACK)) else $error("bad reply head");
   tx_stand_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data)
      && $stable(o_tx_ctrl)) else $error("reply token moved");
   reply_tail_a: assert property (o_tx_valid && i_tx_ready && o_tx_ctrl && o_tx_data == `CRMA_TOK_END
      |=> !o_tx_valid && o_rx_ready) else $error("reply not closed");
   // ==========================================
   // Status port
   ps_answer_a: assert property (i_ps_valid |=> o_ps_done) else $error("no done");
   ps_quiet_a: assert property (!i_ps_valid |=> !o_ps_done) else $error("stray done");
   ps_badres_a: assert property (i_ps_valid && i_ps_resource[7:0] != `CRMA_PS_RES_LOW
      |=> o_ps_error && o_ps_rdata == 32'h0) else $error("bad resource passed");
   ps_hold_a: assert property (!i_ps_valid |=> $stable(o_ps_rdata) && $stable(o_ps_error))
      else $error("status result moved");
   cover property (o_tx_valid && o_tx_data == `CRMA_TOK_NACK);
   cover property (o_tx_valid && !i_tx_ready);
   cover property (o_ps_done && o_ps_error);
endmodule // crma_chk

bind crma_engine crma_chk u_chk (.i_mclk(i_mclk), .i_reset(i_reset), .o_rx_ready(o_rx_ready),
   .o_tx_valid(o_tx_valid), .o_tx_ctrl(o_tx_ctrl), .o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready),
   .i_ps_valid(i_ps_valid), .i_ps_resource(i_ps_resource), .o_ps_rdata(o_ps_rdata),
   .o_ps_done(o_ps_done), .o_ps_error(o_ps_error));

//--- verif/crma_peer.sv
// Remote channel-end model issuing requests and taking replies
`include "crma_defines.vh"
module crma_peer
(
   input wire i_mclk,
   input wire i_rx_ready,
   input wire i_slow,
   output logic o_rx_valid,
   output logic o_rx_ctrl,
   output logic [7:0] o_rx_data,
   output logic o_tx_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] stall_cnt = 2'h0;
   initial
   begin
      o_rx_valid = 1'b0;
      o_rx_ctrl = 1'b0;
      o_rx_data = 8'h00;
   end
   // Slow mode is ready for reply tokens one cycle in four
   always @(posedge i_mclk)
   begin
      stall_cnt <= stall_cnt + 2'h1;
      o_tx_ready <= !i_slow || stall_cnt == 2'h3;
   end
   task automatic send(input logic c, input logic [7:0] d);
      @(negedge i_mclk);
      o_rx_valid = 1'b1;
      o_rx_ctrl = c;
      o_rx_data = d;
      while (!i_rx_ready)
         @(negedge i_mclk);
      @(posedge i_mclk);
   endtask
   // Configuration or peripheral space is picked by the opcode token passed in op
   // Opcode, reply id, number, data, end; fields MSB first
   task automatic message(input logic [7:0] op, input logic [23:0] dest, input logic [15:0] num,
      input int nlen, input logic [31:0] data, input int dlen);
      int i;
      send(1'b1, op);
      for (i = 2; i >= 0; i--)
         send(1'b0, dest[i*8 +: 8]);
      for (i = nlen - 1; i >= 0; i--)
         send(1'b0, num[i*8 +: 8]);
      for (i = dlen - 1; i >= 0; i--)
         send(1'b0, data[i*8 +: 8]);
      send(1'b1, `CRMA_TOK_END);
      @(negedge i_mclk);
      o_rx_valid = 1'b0;
      o_rx_data = ~o_rx_data;
   endtask
endmodule // crma_peer

//--- verif/tb.sv
// Self-checking bench for the configuration message engine
`include "crma_defines.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_mclk = 1'b0;
   logic i_reset = 1'b1;
   logic slow = 1'b0;
   logic rx_valid, rx_ctrl, rx_ready, tx_valid, tx_ctrl, tx_ready, ps_valid, ps_write, ps_done, ps_error;
   logic [7:0] rx_data, tx_data;
   logic [23:0] tx_dest;
   logic [31:0] ps_res, ps_wdata, ps_rdata, seed;
   logic [31:0] vals [8];
   logic [32:0] exp_q [$];
   logic [32:0] ps_q [$];
   int error_cnt = 0;
   int checks_done = 0;
   int cycles = 0;
   int n;
   always #2 i_mclk = ~i_mclk;
   crma_peer p (.i_mclk(i_mclk), .i_rx_ready(rx_ready), .i_slow(slow), .o_rx_valid(rx_valid),
      .o_rx_ctrl(rx_ctrl), .o_rx_data(rx_data), .o_tx_ready(tx_ready));
   crma_engine dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_rx_valid(rx_valid), .i_rx_ctrl(rx_ctrl),
      .i_rx_data(rx_data), .o_rx_ready(rx_ready), .o_tx_valid(tx_valid), .o_tx_ctrl(tx_ctrl),
      .o_tx_data(tx_data), .o_tx_dest(tx_dest), .i_tx_ready(tx_ready), .i_ps_valid(ps_valid),
      .i_ps_write(ps_write), .i_ps_resource(ps_res), .i_ps_wdata(ps_wdata), .o_ps_rdata(ps_rdata),
      .o_ps_done(ps_done), .o_ps_error(ps_error));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [32:0] seen, input logic [32:0] want);
      checks_done++;
      if (seen !== want)
      begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic conclude;
      $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic expect_reply(input logic [23:0] d, input logic ok, input logic [31:0] w, input int nb);
      int i;
      exp_q.push_back({d, 1'b1, ok ? `CRMA_TOK_ACK : `CRMA_TOK_NACK});
      for (i = nb - 1; i >= 0; i--)
         exp_q.push_back({d, 1'b0, w[i*8 +: 8]});
      exp_q.push_back({d, 1'b1, `CRMA_TOK_END});
   endtask
   task automatic drain(input string name);
      int k;
      for (k = 0; k < 400 && exp_q.size() != 0; k++)
         @(negedge i_mclk);
      repeat (20) @(negedge i_mclk);
      check(33'(exp_q.size()), 33'h0);
      $display("Test %s done", name);
   endtask
   task automatic ps(input logic wr, input logic [31:0] res, input logic [31:0] wd, input logic [31:0] rd,
      input logic err);
      @(negedge i_mclk);
      ps_valid = 1'b1;
      ps_write = wr;
      ps_res = res;
      ps_wdata = wd;
      ps_q.push_back({err, rd});
      @(negedge i_mclk);
      ps_valid = 1'b0;
   endtask
   // Each status answer is matched against the oldest note
   always @(negedge i_mclk)
      if (ps_done === 1'b1)
         check({ps_error, ps_rdata}, ps_q.size() ? ps_q.pop_front() : 33'hX);
   // Each reply token taken is matched against the oldest note
   always @(negedge i_mclk)
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
         check({tx_dest, tx_ctrl, tx_data}, exp_q.size() ? exp_q.pop_front() : 33'hX);
   always @(posedge i_mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         error_cnt++;
         conclude();
      end
   end
   initial
   begin
      {ps_valid, ps_write, ps_res, ps_wdata} = '0;
      seed = 32'hF426;
      repeat (10) @(negedge i_mclk);
      i_reset = 1'b0;
      slow = 1'b1;
      for (n = 0; n < 8; n++)
      begin
         seed = lfsr(seed);
         vals[n] = seed;
         expect_reply(seed[23:0], 1'b1, 32'h0, 0);
         p.message(`CRMA_TOK_WRITE, seed[23:0], 16'(n), 2, seed, 4);
         expect_reply(24'h000102, 1'b1, seed, 4);
         p.message(`CRMA_TOK_READ, 24'h000102, 16'(n), 2, 32'h0, 0);
      end
      slow = 1'b0;
      drain("write_read");
      p.message(`CRMA_TOK_WRITE, 24'h0012FF, 16'h0003, 2, 32'hCAFEF00D, 4);
      p.message(`CRMA_TOK_WRITE, 24'h0012FF, 16'h0009, 2, 32'h0, 4);
      vals[3] = 32'hCAFEF00D;
      expect_reply(24'h000102, 1'b1, vals[3], 4);
      p.message(`CRMA_TOK_READ, 24'h000102, 16'h0003, 2, 32'h0, 0);
      drain("no_reply");
      expect_reply(24'h0A0B0C, 1'b0, 32'h0, 0);
      p.message(`CRMA_TOK_WRITE, 24'h0A0B0C, 16'h0008, 2, 32'h1, 4);
      expect_reply(24'h0A0B0C, 1'b0, 32'h0, 0);
      p.message(`CRMA_TOK_READ, 24'h0A0B0C, 16'h0100, 2, 32'h0, 0);
      expect_reply(24'h0A0B0C, 1'b0, 32'h0, 0);
      p.message(`CRMA_TOK_WRITE, 24'h0A0B0C, 16'h0004, 2, 32'h0, 0);
      p.message(8'h55, 24'h0A0B0C, 16'h0004, 2, 32'h0, 4);
      expect_reply(24'h0A0B0C, 1'b1, vals[4], 4);
      p.message(`CRMA_TOK_READ, 24'h0A0B0C, 16'h0004, 2, 32'h0, 0);
      drain("failures");
      expect_reply(24'h00C0DE, 1'b1, vals[2], 4);
      p.message(`CRMA_TOK_PREAD, 24'h00C0DE, 16'h0804, 2, 32'h0, 0);
      expect_reply(24'h00C0DE, 1'b1, vals[7], 4);
      p.message(`CRMA_TOK_PREAD, 24'h00C0DE, 16'h1C04, 2, 32'h0, 0);
      expect_reply(24'h00C0DE, 1'b1, {24'h0, vals[0][31:24]}, 1);
      p.message(`CRMA_TOK_PREAD, 24'h00C0DE, 16'h0001, 2, 32'h0, 0);
      expect_reply(24'h00C0DE, 1'b0, 32'h0, 0);
      p.message(`CRMA_TOK_PREAD, 24'h00C0DE, 16'h1F02, 2, 32'h0, 0);
      expect_reply(24'h00C0DE, 1'b0, 32'h0, 0);
      p.message(`CRMA_TOK_PREAD, 24'h00C0DE, 16'h0000, 2, 32'h0, 0);
      drain("periph");
      seed = lfsr(seed);
      ps(1'b0, 32'h0000030C, 32'h0, 32'h0, 1'b0);
      ps(1'b1, 32'h0000010C, seed, 32'h0, 1'b0);
      ps(1'b0, 32'h0000010C, 32'h0, seed, 1'b0);
      ps(1'b0, 32'h0000040C, 32'h0, 32'h0, 1'b1);
      ps(1'b1, 32'h0000010D, 32'h5, 32'h0, 1'b1);
      ps(1'b0, 32'h0000010C, 32'h0, seed, 1'b0);
      repeat (2) @(negedge i_mclk);
      check(33'(ps_q.size()), 33'h0);
      $display("Test status done");
      conclude();
   end
endmodule // tb
